/* File: kcr_regs.sv */
// What this block does
// - Bank is selected when logical device number is 05h, reached by index.
// - Index 30h bit 0 enables the controller; other bits reserved.
// - Enable reset value comes from the strap level at reset.
// - Index 31h bit 1 enables range check in plug-and-play mode.
// - Range check answers reads in range with 55h or AAh per bit 0.
// - Index 60h: high nibble reads zero, low nibble address 11:8, reset 00h.
// - Index 61h holds data address 7:0, reset 60h.
// - Index 62h: high nibble zero, low nibble command address 11:8, reset 00h.
// - Index 63h holds command address 7:0, reset 64h.
// - Index 70h low nibble selects interrupt line, reset 01h.
// - Index 71h reads fixed 02h unless special bit 1 is set.
// - Type bit 1 picks high level, bit 0 picks level trigger.
// - Special bit 1 makes interrupt type changeable.
// - Index F0h: bit 4 sharing, bit 3 8MHz clock, bit 2 key lock.
// - Special bit 0 picks external program ROM, else internal ROM.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "kcr_params.svh"

module kcr_regs import kcr_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Strap and mode
  input wire logic i_kbd_enable_strap,
  input wire logic i_motherboard_config_mode,
  // Host I/O decode
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  output logic o_data_port_sel,
  output logic o_cmd_port_sel,
  output logic o_range_resp_valid,
  output logic [7:0] o_range_resp_data,
  // Controller configuration
  output logic o_keyboard_controller_en,
  output logic [3:0] o_irq_line,
  output logic o_irq_line_valid,
  output logic o_irq_active_high,
  output logic o_irq_level_trig,
  output logic o_irq_share,
  output logic o_clk_8mhz_sel,
  output logic o_key_lock_en,
  output logic o_ext_rom_sel
);

  if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie in 11..32");
  end

  kcr_state_t state_reg;
  kcr_byte_t ldn_reg;
  logic enable_reg;
  logic strap_reg;
  logic [1:0] range_reg;
  logic [3:0] data_high_reg;
  kcr_byte_t data_low_reg;
  logic [3:0] cmd_high_reg;
  kcr_byte_t cmd_low_reg;
  logic [3:0] irq_level_reg;
  logic [1:0] irq_type_reg;
  logic [4:0] special_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic data_sel_reg;
  logic cmd_sel_reg;
  logic resp_valid_reg;
  kcr_byte_t resp_data_reg;

  kcr_byte_t idx;
  logic upper_zero;
  logic bank_on;
  logic setup;
  logic wr;
  logic mapped;
  kcr_byte_t rd_byte;
  logic [1:0] irq_type_eff;
  logic [15:0] data_addr;
  logic [15:0] cmd_addr;
  logic hit_data;
  logic hit_cmd;
  logic range_active;
  logic range_hit;

  assign idx = i_paddr[9:2];
  assign upper_zero = ((i_paddr >> 10) == '0);
  assign bank_on = (ldn_reg == `KCR_LDN_KEYBOARD);
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite && upper_zero;

  // Zero wait states
  assign o_pready = 1'b1;
  assign o_prdata = prdata_reg;
  assign o_pslverr = pslverr_reg;

  assign irq_type_eff = special_reg[`KCR_SC_TYPE_CHG_BIT] ? irq_type_reg
                                                           : `KCR_RST_IRQ_TYPE;

  // Read mux; reserved bits stay zero
  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `KCR_IDX_LDN: rd_byte = ldn_reg;
      `KCR_IDX_ACTIVATE: rd_byte = {7'h00, enable_reg};
      `KCR_IDX_RANGE_CHECK: rd_byte = {6'h00, range_reg};
      `KCR_IDX_DATA_BASE_HIGH: rd_byte = {4'h0, data_high_reg};
      `KCR_IDX_DATA_BASE_LOW: rd_byte = data_low_reg;
      `KCR_IDX_CMD_BASE_HIGH: rd_byte = {4'h0, cmd_high_reg};
      `KCR_IDX_CMD_BASE_LOW: rd_byte = cmd_low_reg;
      `KCR_IDX_IRQ_LEVEL: rd_byte = {4'h0, irq_level_reg};
      `KCR_IDX_IRQ_TYPE: rd_byte = {6'h00, irq_type_eff};
      `KCR_IDX_SPECIAL_CONFIG: rd_byte = {3'h0, special_reg};
      default: mapped = 1'b0;
    endcase
    if (!upper_zero) begin
      mapped = 1'b0;
    end
    if (!mapped || (!bank_on && idx != `KCR_IDX_LDN)) begin
      rd_byte = 8'h00;
    end
  end

  // Read data and error caught in the setup cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= {24'h00_0000, rd_byte};
      pslverr_reg <= !mapped;
    end
  end

  // Strap capture in the first cycle after release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= KCR_ST_STRAP;
    end else begin
      case (state_reg)
        KCR_ST_STRAP: state_reg <= KCR_ST_RUN;
        KCR_ST_RUN: state_reg <= KCR_ST_RUN;
        default: state_reg <= KCR_ST_STRAP;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ldn_reg <= `KCR_RST_LDN;
    end else if (wr && idx == `KCR_IDX_LDN) begin
      ldn_reg <= i_pwdata[7:0];
    end
  end

  // Strap level taken while reset is held low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_reg <= i_kbd_enable_strap;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_reg <= 1'b0;
    end else if (state_reg == KCR_ST_STRAP) begin
      enable_reg <= strap_reg;
    end else if (wr && bank_on && idx == `KCR_IDX_ACTIVATE) begin
      enable_reg <= i_pwdata[`KCR_ACT_EN_BIT];
    end
  end

  // Bank registers; reserved write bits dropped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      range_reg <= `KCR_RST_RANGE_CHECK;
      data_high_reg <= `KCR_RST_DATA_BASE_HIGH;
      data_low_reg <= `KCR_RST_DATA_BASE_LOW;
      cmd_high_reg <= `KCR_RST_CMD_BASE_HIGH;
      cmd_low_reg <= `KCR_RST_CMD_BASE_LOW;
      irq_level_reg <= `KCR_RST_IRQ_LEVEL;
      irq_type_reg <= `KCR_RST_IRQ_TYPE;
      special_reg <= `KCR_RST_SPECIAL_CONFIG;
    end else if (wr && bank_on) begin
      case (idx)
        `KCR_IDX_RANGE_CHECK: range_reg <= i_pwdata[1:0];
        `KCR_IDX_DATA_BASE_HIGH: data_high_reg <= i_pwdata[3:0];
        `KCR_IDX_DATA_BASE_LOW: data_low_reg <= i_pwdata[7:0];
        `KCR_IDX_CMD_BASE_HIGH: cmd_high_reg <= i_pwdata[3:0];
        `KCR_IDX_CMD_BASE_LOW: cmd_low_reg <= i_pwdata[7:0];
        `KCR_IDX_IRQ_LEVEL: irq_level_reg <= i_pwdata[3:0];
        `KCR_IDX_IRQ_TYPE: begin
          if (special_reg[`KCR_SC_TYPE_CHG_BIT]) begin
            irq_type_reg <= i_pwdata[1:0];
          end
        end
        `KCR_IDX_SPECIAL_CONFIG: special_reg <= i_pwdata[4:0];
        default: ;
      endcase
    end
  end

  // Host port decode
  assign data_addr = {4'h0, data_high_reg, data_low_reg};
  assign cmd_addr = {4'h0, cmd_high_reg, cmd_low_reg};
  assign hit_data = (i_io_addr == data_addr);
  assign hit_cmd = (i_io_addr == cmd_addr);
  assign range_active = range_reg[`KCR_RC_EN_BIT] && !i_motherboard_config_mode;
  assign range_hit = range_active && i_io_rd && (hit_data || hit_cmd);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_sel_reg <= 1'b0;
      cmd_sel_reg <= 1'b0;
    end else begin
      data_sel_reg <= enable_reg && (i_io_rd || i_io_wr) && hit_data;
      cmd_sel_reg <= enable_reg && (i_io_rd || i_io_wr) && hit_cmd;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resp_valid_reg <= 1'b0;
      resp_data_reg <= 8'h00;
    end else begin
      resp_valid_reg <= range_hit;
      if (!range_hit) begin
        resp_data_reg <= 8'h00;
      end else if (range_reg[`KCR_RC_PAT_BIT]) begin
        resp_data_reg <= `KCR_RC_PAT_SET;
      end else begin
        resp_data_reg <= `KCR_RC_PAT_CLR;
      end
    end
  end

  assign o_data_port_sel = data_sel_reg;
  assign o_cmd_port_sel = cmd_sel_reg;
  assign o_range_resp_valid = resp_valid_reg;
  assign o_range_resp_data = resp_data_reg;

  // Configuration outputs
  assign o_keyboard_controller_en = enable_reg;
  assign o_irq_line = irq_level_reg;
  assign o_irq_line_valid = (irq_level_reg != `KCR_IRQ_NONE)
                         && (irq_level_reg != `KCR_IRQ_BAD)
                         && (irq_level_reg <= `KCR_IRQ_MAX);
  assign o_irq_active_high = irq_type_eff[1];
  assign o_irq_level_trig = irq_type_eff[0];
  assign o_irq_share = special_reg[`KCR_SC_SHARE_BIT];
  assign o_clk_8mhz_sel = special_reg[`KCR_SC_CLK8_BIT];
  assign o_key_lock_en = special_reg[`KCR_SC_KEYLOCK_BIT];
  assign o_ext_rom_sel = special_reg[`KCR_SC_EXT_ROM_BIT];

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_bank_write(kcr_byte_t ix);
    wr && bank_on && idx == ix;
  endsequence

  sequence s_read_setup(kcr_byte_t ix);
    setup && !i_pwrite && upper_zero && bank_on && idx == ix;
  endsequence

  sequence s_range_read;
    range_active && i_io_rd && (hit_data || hit_cmd);
  endsequence

  AST_STRAP_LOAD: assert property (
    state_reg == KCR_ST_STRAP |=> o_keyboard_controller_en == $past(i_kbd_enable_strap, 2))
    else $error("enable not loaded from strap");

  AST_BANK_GATE: assert property (
    wr && !bank_on && idx == `KCR_IDX_ACTIVATE && state_reg == KCR_ST_RUN
    |=> $stable(enable_reg))
    else $error("write reached bank while other device selected");

  AST_ACTIVATE_WR: assert property (
    s_bank_write(`KCR_IDX_ACTIVATE) and state_reg == KCR_ST_RUN
    |=> o_keyboard_controller_en == $past(i_pwdata[0]))
    else $error("activate bit not written");

  AST_RANGE_55: assert property (
    s_range_read and range_reg[0] |=> o_range_resp_valid && o_range_resp_data == 8'h55)
    else $error("range check did not answer 55h");

  AST_RANGE_AA: assert property (
    s_range_read and !range_reg[0] |=> o_range_resp_valid && o_range_resp_data == 8'haa)
    else $error("range check did not answer AAh");

  AST_HIGH_ZERO: assert property (
    s_read_setup(`KCR_IDX_DATA_BASE_HIGH) ##1 i_penable |-> o_prdata[31:4] == '0
    && o_prdata[3:0] == data_high_reg)
    else $error("data base high read wrong");

  AST_ACT_RESERVED: assert property (
    s_read_setup(`KCR_IDX_ACTIVATE) |=> o_prdata == {31'h0, enable_reg})
    else $error("activate reserved bits not zero");

  AST_TYPE_FIXED: assert property (
    !special_reg[1] |-> o_irq_active_high && !o_irq_level_trig)
    else $error("fixed interrupt type not 02h");

  AST_DECODE_EN: assert property (
    o_data_port_sel || o_cmd_port_sel |-> $past(enable_reg))
    else $error("port decoded while disabled");

  AST_IRQ_VALID: assert property (
    o_irq_line_valid == !(o_irq_line inside {4'h0, 4'h2, 4'hd, 4'he, 4'hf}))
    else $error("interrupt line validity wrong");

  AST_LOW_WR: assert property (
    s_bank_write(`KCR_IDX_DATA_BASE_LOW) |=> data_low_reg == $past(i_pwdata[7:0]))
    else $error("data base low not written");

  AST_TYPE_HOLD: assert property (
    s_bank_write(`KCR_IDX_IRQ_TYPE) and !special_reg[1] |=> $stable(irq_type_reg))
    else $error("fixed interrupt type was written");

  AST_SPECIAL_OUT: assert property (
    s_bank_write(`KCR_IDX_SPECIAL_CONFIG) |=> o_irq_share == $past(i_pwdata[4])
    && o_clk_8mhz_sel == $past(i_pwdata[3]) && o_key_lock_en == $past(i_pwdata[2]))
    else $error("special configuration outputs wrong");

  AST_EXT_ROM: assert property (
    s_bank_write(`KCR_IDX_SPECIAL_CONFIG) |=> o_ext_rom_sel == $past(i_pwdata[0]))
    else $error("program ROM select wrong");

  AST_UNMAPPED: assert property (
    setup && !mapped |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

endmodule : kcr_regs

/* File: kcr_params.svh */
`ifndef KCR_PARAMS_SVH
`define KCR_PARAMS_SVH

// Logical device served by this bank
`define KCR_LDN_KEYBOARD 8'h05

// Register indices; byte address is four times the index
`define KCR_IDX_LDN 8'h07
`define KCR_IDX_ACTIVATE 8'h30
`define KCR_IDX_RANGE_CHECK 8'h31
`define KCR_IDX_DATA_BASE_HIGH 8'h60
`define KCR_IDX_DATA_BASE_LOW 8'h61
`define KCR_IDX_CMD_BASE_HIGH 8'h62
`define KCR_IDX_CMD_BASE_LOW 8'h63
`define KCR_IDX_IRQ_LEVEL 8'h70
`define KCR_IDX_IRQ_TYPE 8'h71
`define KCR_IDX_SPECIAL_CONFIG 8'hf0

// Field positions
`define KCR_ACT_EN_BIT 0
`define KCR_RC_EN_BIT 1
`define KCR_RC_PAT_BIT 0
`define KCR_SC_SHARE_BIT 4
`define KCR_SC_CLK8_BIT 3
`define KCR_SC_KEYLOCK_BIT 2
`define KCR_SC_TYPE_CHG_BIT 1
`define KCR_SC_EXT_ROM_BIT 0

// Reset values
`define KCR_RST_LDN 8'h00
`define KCR_RST_RANGE_CHECK 2'h0
`define KCR_RST_DATA_BASE_HIGH 4'h0
`define KCR_RST_DATA_BASE_LOW 8'h60
`define KCR_RST_CMD_BASE_HIGH 4'h0
`define KCR_RST_CMD_BASE_LOW 8'h64
`define KCR_RST_IRQ_LEVEL 4'h1
`define KCR_RST_IRQ_TYPE 2'h2
`define KCR_RST_SPECIAL_CONFIG 5'h00

// Range check answers and line limits
`define KCR_RC_PAT_SET 8'h55
`define KCR_RC_PAT_CLR 8'haa
`define KCR_IRQ_NONE 4'h0
`define KCR_IRQ_BAD 4'h2
`define KCR_IRQ_MAX 4'hc

`endif

/* File: kcr_pkg.sv */
package kcr_pkg;

  typedef logic [7:0] kcr_byte_t;

  // Strap capture sequence after reset release
  typedef enum logic [1:0] {
    KCR_ST_STRAP = 2'b01,
    KCR_ST_RUN = 2'b10
  } kcr_state_t;

endpackage : kcr_pkg

/* File: tb.sv */
`timescale 1ns/1ps
`include "kcr_params.svh"

module tb;
  import kcr_pkg::*;

  logic i_clk;
  logic i_rst_n;
  logic i_psel;
  logic i_penable;
  logic i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic i_kbd_enable_strap;
  logic i_motherboard_config_mode;
  logic [15:0] i_io_addr;
  logic i_io_rd;
  logic i_io_wr;
  wire o_pready, o_pslverr, o_data_port_sel, o_cmd_port_sel, o_range_resp_valid;
  wire [31:0] o_prdata;
  wire [7:0] o_range_resp_data;
  wire [3:0] o_irq_line;
  wire o_keyboard_controller_en, o_irq_line_valid, o_irq_active_high, o_irq_level_trig;
  wire o_irq_share, o_clk_8mhz_sel, o_key_lock_en, o_ext_rom_sel;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] ix [9] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'hf0};
  logic [7:0] rst_v [9] = '{8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h64, 8'h01, 8'h02, 8'h00};
  logic [7:0] msk [9] = '{8'h01, 8'h03, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h02, 8'h1f};

  kcr_regs #(.ADDR_W(12)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_kbd_enable_strap(i_kbd_enable_strap),
    .i_motherboard_config_mode(i_motherboard_config_mode),
    .i_io_addr(i_io_addr), .i_io_rd(i_io_rd), .i_io_wr(i_io_wr),
    .o_data_port_sel(o_data_port_sel), .o_cmd_port_sel(o_cmd_port_sel),
    .o_range_resp_valid(o_range_resp_valid), .o_range_resp_data(o_range_resp_data),
    .o_keyboard_controller_en(o_keyboard_controller_en),
    .o_irq_line(o_irq_line), .o_irq_line_valid(o_irq_line_valid),
    .o_irq_active_high(o_irq_active_high), .o_irq_level_trig(o_irq_level_trig),
    .o_irq_share(o_irq_share), .o_clk_8mhz_sel(o_clk_8mhz_sel),
    .o_key_lock_en(o_key_lock_en), .o_ext_rom_sel(o_ext_rom_sel)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t exp %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= {24'h0, wd};
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    // Let the write settle before outputs are compared
    #1;
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(e, rd[7:0]);
  endtask : rdc

  // Host I/O pulse; selects and range answer land one cycle after it
  task automatic io(input logic r, input logic [15:0] a, input logic [2:0] es,
                    input logic [7:0] ed);
    @(posedge i_clk);
    i_io_rd <= r;
    i_io_wr <= ~r;
    i_io_addr <= a;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    i_io_wr <= 1'b0;
    #1;
    chk({5'h0, es}, {5'h0, o_data_port_sel, o_cmd_port_sel, o_range_resp_valid});
    chk(ed, o_range_resp_data);
  endtask : io

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_kbd_enable_strap = 1'b1;
    i_motherboard_config_mode = 1'b0;
    i_io_addr = 16'h0000;
    i_io_rd = 1'b0;
    i_io_wr = 1'b0;
    repeat (4) @(posedge i_clk);
    chk(8'h11, {3'h0, o_irq_active_high, o_irq_line});
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(8'h01, {7'h0, o_keyboard_controller_en});
    rdc(`KCR_IDX_CMD_BASE_LOW, 8'h00);
    wr(`KCR_IDX_LDN, `KCR_LDN_KEYBOARD);
    for (int i = 0; i < 9; i++) rdc(ix[i], rst_v[i]);
    for (int i = 2; i < 9; i++) wr(ix[i], 8'hff);
    for (int i = 2; i < 9; i++) rdc(ix[i], msk[i]);
    chk(8'h0f, {o_irq_share, o_clk_8mhz_sel, o_key_lock_en, o_ext_rom_sel});
    wr(`KCR_IDX_IRQ_TYPE, 8'hff);
    rdc(`KCR_IDX_IRQ_TYPE, 8'h03);
    wr(`KCR_IDX_IRQ_TYPE, 8'h01);
    chk(8'h01, {6'h0, o_irq_active_high, o_irq_level_trig});
    wr(`KCR_IDX_SPECIAL_CONFIG, 8'h00);
    rdc(`KCR_IDX_IRQ_TYPE, 8'h02);
    chk(8'h02, {6'h0, o_irq_active_high, o_irq_level_trig});
    chk(8'h00, {o_irq_share, o_clk_8mhz_sel, o_key_lock_en, o_ext_rom_sel});
    wr(`KCR_IDX_ACTIVATE, 8'hfe);
    rdc(`KCR_IDX_ACTIVATE, 8'h00);
    wr(`KCR_IDX_ACTIVATE, 8'hff);
    chk(8'h01, {7'h0, o_keyboard_controller_en});
    wr(`KCR_IDX_LDN, 8'h06);
    wr(`KCR_IDX_ACTIVATE, 8'h00);
    chk(8'h01, {7'h0, o_keyboard_controller_en});
    wr(`KCR_IDX_LDN, `KCR_LDN_KEYBOARD);
    for (int v = 0; v < 16; v++) begin
      wr(`KCR_IDX_IRQ_LEVEL, 8'(v));
      chk({3'h0, (v != 0 && v != 2 && v <= 12), 4'(v)}, {3'h0, o_irq_line_valid, o_irq_line});
    end
    // Data port 0123h, command port 0245h
    wr(`KCR_IDX_DATA_BASE_HIGH, 8'h01);
    wr(`KCR_IDX_DATA_BASE_LOW, 8'h23);
    wr(`KCR_IDX_CMD_BASE_HIGH, 8'h02);
    wr(`KCR_IDX_CMD_BASE_LOW, 8'h45);
    io(1'b1, 16'h0123, 3'b100, 8'h00);
    io(1'b0, 16'h0245, 3'b010, 8'h00);
    io(1'b1, 16'h1123, 3'b000, 8'h00);
    wr(`KCR_IDX_ACTIVATE, 8'h00);
    io(1'b1, 16'h0123, 3'b000, 8'h00);
    wr(`KCR_IDX_RANGE_CHECK, 8'h03);
    io(1'b1, 16'h0123, 3'b001, 8'h55);
    wr(`KCR_IDX_RANGE_CHECK, 8'h02);
    io(1'b1, 16'h0245, 3'b001, 8'haa);
    io(1'b0, 16'h0245, 3'b000, 8'h00);
    i_motherboard_config_mode <= 1'b1;
    io(1'b1, 16'h0123, 3'b000, 8'h00);
    apb(1'b0, 8'h32, 8'h00);
    chk(8'h01, {7'h0, err});
    chk(8'h00, rd[7:0]);
    // Second reset with the strap low
    i_kbd_enable_strap <= 1'b0;
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk(8'h00, {7'h0, o_keyboard_controller_en});
    rdc(`KCR_IDX_CMD_BASE_LOW, 8'h00);
    print_verdict();
  end
endmodule : tb
